// ==== logic/bridge_secondary_control_consts.svh ====
`ifndef BRIDGE_SECONDARY_CONTROL_CONSTS_SVH
`define BRIDGE_SECONDARY_CONTROL_CONSTS_SVH

// =====================================================================
// register placement
// =====================================================================
`define BSC_OFFSET          8'h3E
`define BSC_RESET           16'h0000
`define BSC_WRITABLE        16'h0B6F

// =====================================================================
// field positions
// =====================================================================
`define BSC_PARITY_RESP     0
`define BSC_SERR_FWD        1
`define BSC_ISA_EN          2
`define BSC_VGA_EN          3
`define BSC_RSVD4           4
`define BSC_MA_MODE         5
`define BSC_SEC_RESET       6
`define BSC_FAST_B2B        7
`define BSC_PRI_SHORT       8
`define BSC_SEC_SHORT       9
`define BSC_DISCARD_STAT    10
`define BSC_DISCARD_SERR    11

// =====================================================================
// discard timer lengths in link clocks
// =====================================================================
`define DISCARD_LONG_CLKS   32768
`define DISCARD_SHORT_CLKS  1024

// =====================================================================
// address ranges
// =====================================================================
`define VGA_MEM_LO          32'h000A0000
`define VGA_MEM_HI          32'h000BFFFF
`define VGA_IO_A_LO         16'h03B0
`define VGA_IO_A_HI         16'h03BB
`define VGA_IO_B_LO         16'h03C0
`define VGA_IO_B_HI         16'h03DF
`define MASTER_ABORT_DATA   32'hFFFFFFFF

`endif

// ==== logic/bridge_secondary_control_pkg.sv ====
package bridge_secondary_control_pkg;

	// control register image
	typedef logic [15:0] ctrl_word_t;

	// kind of access offered for a forwarding decision
	typedef enum logic [1:0]
	{
		ACC_NONE,
		ACC_MEM,
		ACC_IO
	} access_kind_t;

endpackage

// ==== logic/bridge_secondary_control.sv ====
// Overview of operation
// - bit 9 picks secondary discard length
// - bit 8 picks primary discard length
// - no fast back-to-back; bit 7 zero
// - bit 6 holds secondary reset asserted
// - mode clear: reads all ones, writes dropped
// - mode set: target abort or system error
// - VGA memory range forwarded downstream
// - VGA I/O ranges forwarded downstream
// - VGA ranges never forwarded upstream
// - VGA forwarding overrides ISA blocking
// - ISA blocks top 768 bytes downstream
// - ISA top 768 bytes forwarded upstream
// - bit 1 forwards secondary system error
// - system error gated by command bit 8
// - bit 0 enables secondary parity reporting
// - reserved bit 4 reads zero
// - expiry drops request, sets sticky bit 10
// - bit 11 gates system error on primary timeout
`timescale 1ns/1ps
`default_nettype none

`include "bridge_secondary_control_consts.svh"

// =====================================================================
// discard timer: counts link clock ticks while armed
// =====================================================================
module discard_timer
#(
	parameter int LONG_CLKS  = `DISCARD_LONG_CLKS,
	parameter int SHORT_CLKS = `DISCARD_SHORT_CLKS
)
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic link_tick,
	input  wire logic short_sel,
	input  wire logic result_ready,
	input  wire logic completed,
	output logic      armed,
	output logic      expired
);

	logic [15:0] ticks;   // link clocks since arming
	logic [15:0] limit;   // selected length minus one

	// length choice follows the select bit live
	assign limit = short_sel ? 16'(SHORT_CLKS - 1) : 16'(LONG_CLKS - 1);

	// arm on ready, disarm on completion or expiry
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			armed   <= 1'b0;
			ticks   <= 16'h0000;
			expired <= 1'b0;
		end
		else
		begin
			expired <= 1'b0;
			if (completed)
			begin
				// master came back in time
				armed <= 1'b0;
				ticks <= 16'h0000;
			end
			else if (result_ready && !armed)
			begin
				armed <= 1'b1;
				ticks <= 16'h0000;
			end
			else if (armed && link_tick)
			begin
				if (ticks >= limit)
				begin
					// drop the queued result
					armed   <= 1'b0;
					expired <= 1'b1;
					ticks   <= 16'h0000;
				end
				else
				begin
					ticks <= ticks + 16'h0001;
				end
			end
		end
	end

endmodule

// =====================================================================
// control block for the secondary side of the bridge
// =====================================================================
module bridge_secondary_control
	import bridge_secondary_control_pkg::*;
#(
	parameter int LONG_CLKS  = `DISCARD_LONG_CLKS,
	parameter int SHORT_CLKS = `DISCARD_SHORT_CLKS
)
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        pci_clk,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [1:0]  cfg_be,
	input  wire logic [15:0] cfg_wdata,
	output logic      [15:0] cfg_rdata,
	input  wire logic        cmd_serr_en,
	input  wire logic        downstream_system_error_in_n,
	input  wire logic        sec_parity_error,
	input  wire logic        pri_result_ready,
	input  wire logic        pri_completed,
	input  wire logic        sec_result_ready,
	input  wire logic        sec_completed,
	input  wire logic        master_abort,
	input  wire logic        master_abort_read,
	input  wire logic        master_abort_pending,
	input  wire logic        req_valid,
	input  wire logic        req_from_primary,
	input  wire logic        req_is_io,
	input  wire logic [31:0] req_addr,
	input  wire logic [31:0] io_base,
	input  wire logic [31:0] io_limit,
	input  wire logic [31:0] mem_base,
	input  wire logic [31:0] mem_limit,
	output logic             fwd_valid,
	output logic             fwd_accept,
	output logic             ma_read_valid,
	output logic      [31:0] ma_read_data,
	output logic             ma_write_discard,
	output logic             ma_target_abort,
	output logic             pri_discard,
	output logic             sec_discard,
	output logic             fast_b2b_enable,
	output logic             downstream_reset_out_n,
	output logic             upstream_system_error_o,
	output logic             upstream_system_error_oe_n,
	output logic             downstream_parity_error_o,
	output logic             downstream_parity_error_oe_n
);

	// =================================================================
	// pin synchronisers
	// =================================================================
	logic       clk_meta;     // link clock, first stage
	logic       clk_sync;     // link clock, second stage
	logic       clk_prev;     // edge detect history
	logic       link_tick;    // one cycle per link clock rise
	logic       serr_meta;    // secondary error, first stage
	logic       serr_sync_n;  // secondary error, second stage

	// two stages ahead of any reader
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			clk_meta    <= 1'b0;
			clk_sync    <= 1'b0;
			clk_prev    <= 1'b0;
			serr_meta   <= 1'b1;
			serr_sync_n <= 1'b1;
		end
		else
		begin
			clk_meta    <= pci_clk;
			clk_sync    <= clk_meta;
			clk_prev    <= clk_sync;
			serr_meta   <= downstream_system_error_in_n;
			serr_sync_n <= serr_meta;
		end
	end

	assign link_tick = clk_sync && !clk_prev;

	// =================================================================
	// control register
	// =================================================================
	ctrl_word_t ctrl;          // stored control bits
	ctrl_word_t wmask;         // lanes written this cycle
	ctrl_word_t ctrl_view;     // value seen by reads
	logic       hit;           // access to this register
	logic       pri_expired;   // primary timer expiry pulse
	logic       sec_expired;   // secondary timer expiry pulse

	assign hit   = cfg_addr == `BSC_OFFSET;
	assign wmask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};

	// reserved, fast back-to-back bits forced low
	always_comb
	begin
		ctrl_view                    = ctrl;
		ctrl_view[15:12]             = 4'h0;
		ctrl_view[`BSC_FAST_B2B]     = 1'b0;
		ctrl_view[`BSC_RSVD4]        = 1'b0;
	end

	// writable bits follow enabled lanes; sticky discard status, a new expiry beats the clear
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl <= `BSC_RESET;
		end
		else
		begin
			if (cfg_wr && hit)
			begin
				// status bit lies outside the writable mask, so it keeps its value here
				ctrl <= (ctrl & ~(wmask & `BSC_WRITABLE)) | (cfg_wdata & wmask & `BSC_WRITABLE);
			end
			if (pri_expired || sec_expired)
			begin
				ctrl[`BSC_DISCARD_STAT] <= 1'b1;
			end
			else if (cfg_wr && hit && cfg_be[1] && cfg_wdata[`BSC_DISCARD_STAT])
			begin
				ctrl[`BSC_DISCARD_STAT] <= 1'b0;
			end
		end
	end

	// read data one cycle after the strobe, zero when unmapped
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cfg_rdata <= 16'h0000;
		end
		else if (cfg_rd)
		begin
			cfg_rdata <= hit ? ctrl_view : 16'h0000;
		end
	end

	// =================================================================
	// discard timers
	// =================================================================
	discard_timer #(.LONG_CLKS(LONG_CLKS), .SHORT_CLKS(SHORT_CLKS)) u_pri_timer
	(
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.link_tick    (link_tick),
		.short_sel    (ctrl[`BSC_PRI_SHORT]),
		.result_ready (pri_result_ready),
		.completed    (pri_completed),
		.armed        (),
		.expired      (pri_expired)
	);

	discard_timer #(.LONG_CLKS(LONG_CLKS), .SHORT_CLKS(SHORT_CLKS)) u_sec_timer
	(
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.link_tick    (link_tick),
		.short_sel    (ctrl[`BSC_SEC_SHORT]),
		.result_ready (sec_result_ready),
		.completed    (sec_completed),
		.armed        (),
		.expired      (sec_expired)
	);

	// discard pulses to the queue
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pri_discard <= 1'b0;
			sec_discard <= 1'b0;
		end
		else
		begin
			pri_discard <= pri_expired;
			sec_discard <= sec_expired;
		end
	end

	// =================================================================
	// secondary reset and fast back-to-back
	// =================================================================
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			downstream_reset_out_n <= 1'b0;
			fast_b2b_enable        <= 1'b0;
		end
		else
		begin
			downstream_reset_out_n <= !ctrl[`BSC_SEC_RESET];
			fast_b2b_enable        <= 1'b0;
		end
	end

	// =================================================================
	// master abort handling
	// =================================================================
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			ma_read_valid    <= 1'b0;
			ma_read_data     <= 32'h00000000;
			ma_write_discard <= 1'b0;
			ma_target_abort  <= 1'b0;
		end
		else
		begin
			// quiet mode: fake all-ones reads, swallow writes
			ma_read_valid    <= master_abort && !ctrl[`BSC_MA_MODE] && master_abort_read;
			ma_read_data     <= `MASTER_ABORT_DATA;
			ma_write_discard <= master_abort && !ctrl[`BSC_MA_MODE] && !master_abort_read;
			// report mode: abort the still-waiting requester
			ma_target_abort  <= master_abort && ctrl[`BSC_MA_MODE] && master_abort_pending;
		end
	end

	// =================================================================
	// primary system error
	// =================================================================
	logic serr_event;   // any enabled cause this cycle
	logic serr_hold;    // stretch to the next link clock rise

	assign serr_event = cmd_serr_en
		&& ((ctrl[`BSC_SERR_FWD] && !serr_sync_n)
		|| (ctrl[`BSC_DISCARD_SERR] && pri_expired)
		|| (ctrl[`BSC_MA_MODE] && master_abort && !master_abort_pending));

	// event wins over the end of the stretch
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			serr_hold <= 1'b0;
		end
		else if (serr_event)
		begin
			serr_hold <= 1'b1;
		end
		else if (link_tick)
		begin
			serr_hold <= 1'b0;
		end
	end

	// open drain: only ever drive low
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			upstream_system_error_o    <= 1'b0;
			upstream_system_error_oe_n <= 1'b1;
		end
		else
		begin
			upstream_system_error_o    <= 1'b0;
			upstream_system_error_oe_n <= !(serr_hold || serr_event);
		end
	end

	// =================================================================
	// secondary parity error
	// =================================================================
	logic perr_hold;   // stretch to the next link clock rise

	// detection ignored while response disabled
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			perr_hold <= 1'b0;
		end
		else if (sec_parity_error && ctrl[`BSC_PARITY_RESP])
		begin
			perr_hold <= 1'b1;
		end
		else if (link_tick)
		begin
			perr_hold <= 1'b0;
		end
	end

	// drive low while a report is held
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			downstream_parity_error_o    <= 1'b0;
			downstream_parity_error_oe_n <= 1'b1;
		end
		else
		begin
			downstream_parity_error_o    <= 1'b0;
			downstream_parity_error_oe_n <= !perr_hold;
		end
	end

	// =================================================================
	// forwarding decode
	// =================================================================
	logic in_io_win;   // inside the I/O window
	logic in_mem_win;  // inside the memory window
	logic vga_mem;     // legacy frame buffer hit
	logic vga_io;      // legacy I/O port hit
	logic vga_hit;     // either legacy range with VGA on
	logic isa_top;     // top 768 bytes of a 1K block, low 64K
	logic next_accept; // forwarding decision

	assign in_io_win  = req_addr >= io_base && req_addr <= io_limit;
	assign in_mem_win = req_addr >= mem_base && req_addr <= mem_limit;
	assign vga_mem    = !req_is_io && req_addr >= `VGA_MEM_LO && req_addr <= `VGA_MEM_HI;
	assign vga_io     = req_is_io && req_addr[31:16] == 16'h0000
		&& ((req_addr[15:0] >= `VGA_IO_A_LO && req_addr[15:0] <= `VGA_IO_A_HI)
		|| (req_addr[15:0] >= `VGA_IO_B_LO && req_addr[15:0] <= `VGA_IO_B_HI));
	assign vga_hit    = ctrl[`BSC_VGA_EN] && (vga_mem || vga_io);
	assign isa_top    = req_addr[31:16] == 16'h0000 && req_addr[9:8] != 2'b00;

	// legacy ranges first, then windows
	always_comb
	begin
		if (req_from_primary)
		begin
			if (vga_hit)
				next_accept = 1'b1;
			else if (req_is_io)
				next_accept = in_io_win && !(ctrl[`BSC_ISA_EN] && isa_top);
			else
				next_accept = in_mem_win;
		end
		else
		begin
			if (vga_hit)
				next_accept = 1'b0;
			else if (req_is_io)
				next_accept = !in_io_win || (ctrl[`BSC_ISA_EN] && isa_top);
			else
				next_accept = !in_mem_win;
		end
	end

	// decision answered one cycle after the request
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			fwd_valid  <= 1'b0;
			fwd_accept <= 1'b0;
		end
		else
		begin
			fwd_valid  <= req_valid;
			fwd_accept <= req_valid && next_accept;
		end
	end

endmodule

`default_nettype wire

// ==== tb/bridge_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// far side: free-running link clock, secondary error pin, pulled-up wires
// =====================================================================
module bridge_far_end
(
	input  wire logic serr_assert,
	input  wire logic up_o,
	input  wire logic up_oe_n,
	input  wire logic dn_o,
	input  wire logic dn_oe_n,
	output var  logic pci_clk,
	output wire logic serr_pin_n,
	output wire logic up_level,
	output wire logic dn_level
);
	// link clock, phase unrelated to the system clock
	initial
	begin
		pci_clk = 1'b0;
		#7;
		forever #32 pci_clk = ~pci_clk;
	end
	// open-drain pins float high through their pull-ups when released
	assign serr_pin_n = serr_assert ? 1'b0 : 1'b1;
	assign up_level   = up_oe_n ? 1'b1 : up_o;
	assign dn_level   = dn_oe_n ? 1'b1 : dn_o;
endmodule
`default_nettype wire

// ==== tb/bridge_secondary_control_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// port checks for the secondary control block
// =====================================================================
module bridge_secondary_control_assertions
#(
	parameter int LONG_CLKS  = 32768,
	parameter int SHORT_CLKS = 1024
)
(
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        cfg_wr,
	input wire logic        cfg_rd,
	input wire logic [7:0]  cfg_addr,
	input wire logic [1:0]  cfg_be,
	input wire logic [15:0] cfg_wdata,
	input wire logic [15:0] cfg_rdata,
	input wire logic        cmd_serr_en,
	input wire logic        sec_parity_error,
	input wire logic        master_abort,
	input wire logic        req_valid,
	input wire logic        fwd_valid,
	input wire logic        fwd_accept,
	input wire logic        ma_read_valid,
	input wire logic [31:0] ma_read_data,
	input wire logic        ma_write_discard,
	input wire logic        ma_target_abort,
	input wire logic        pri_discard,
	input wire logic        fast_b2b_enable,
	input wire logic        downstream_reset_out_n,
	input wire logic        upstream_system_error_o,
	input wire logic        upstream_system_error_oe_n,
	input wire logic        downstream_parity_error_oe_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_fast_b2b_off: assert property (fast_b2b_enable == 1'b0)
		else $error("fast back-to-back enable raised");
	a_reserved_bits_zero: assert property (cfg_rd && cfg_addr == 8'h3E |=>
		cfg_rdata[15:12] == 4'h0 && cfg_rdata[7] == 1'b0 && cfg_rdata[4] == 1'b0)
		else $error("reserved control bits read nonzero");
	a_reset_tracks_bit: assert property (cfg_wr && cfg_addr == 8'h3E && cfg_be[0] |->
		##2 downstream_reset_out_n == !$past(cfg_wdata[6], 2))
		else $error("secondary reset does not follow control bit");
	a_fwd_one_cycle: assert property (req_valid |=> fwd_valid)
		else $error("decode answer missing");
	a_accept_qualified: assert property (fwd_accept |-> fwd_valid)
		else $error("accept without decode answer");
	a_abort_all_ones: assert property (ma_read_valid |-> ma_read_data == 32'hFFFFFFFF)
		else $error("master abort read data not all ones");
	a_abort_has_cause: assert property ((ma_read_valid || ma_write_discard || ma_target_abort)
		|-> $past(master_abort))
		else $error("abort response without master abort");
	a_serr_needs_enable: assert property ($fell(upstream_system_error_oe_n) |-> $past(cmd_serr_en))
		else $error("system error driven while disabled");
	a_serr_drives_low: assert property (upstream_system_error_o == 1'b0)
		else $error("system error pin driven high");
	a_perr_has_cause: assert property ($fell(downstream_parity_error_oe_n)
		|-> $past(sec_parity_error, 2))
		else $error("parity error output without detected error");
	a_discard_single: assert property (pri_discard |=> !pri_discard)
		else $error("discard pulse longer than one cycle");
endmodule

bind bridge_secondary_control bridge_secondary_control_assertions
#(
	.LONG_CLKS(LONG_CLKS),
	.SHORT_CLKS(SHORT_CLKS)
)
chk
(
	.clk_sys(clk_sys), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
	.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cmd_serr_en(cmd_serr_en),
	.sec_parity_error(sec_parity_error), .master_abort(master_abort), .req_valid(req_valid),
	.fwd_valid(fwd_valid), .fwd_accept(fwd_accept), .ma_read_valid(ma_read_valid),
	.ma_read_data(ma_read_data), .ma_write_discard(ma_write_discard), .ma_target_abort(ma_target_abort),
	.pri_discard(pri_discard), .fast_b2b_enable(fast_b2b_enable),
	.downstream_reset_out_n(downstream_reset_out_n), .upstream_system_error_o(upstream_system_error_o),
	.upstream_system_error_oe_n(upstream_system_error_oe_n),
	.downstream_parity_error_oe_n(downstream_parity_error_oe_n)
);
`default_nettype wire

// ==== tb/bridge_secondary_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module bridge_secondary_control_tb_top;
	// row: control word, {downstream, io, accept}, address
	typedef struct packed {logic [15:0] c; logic [2:0] f; logic [31:0] a;} row_t;
	row_t rows [17] = '{
		'{16'h0008, 3'h5, 32'h000A0000}, '{16'h0008, 3'h5, 32'h000BFFFF}, '{16'h0000, 3'h4, 32'h000A0000},
		'{16'h0008, 3'h7, 32'h000003B0}, '{16'h0008, 3'h7, 32'h000003BB}, '{16'h0008, 3'h6, 32'h000003BC},
		'{16'h0008, 3'h7, 32'h000003C0}, '{16'h0008, 3'h7, 32'h000003DF}, '{16'h000C, 3'h7, 32'h000003C0},
		'{16'h0008, 3'h0, 32'h000A0000}, '{16'h0008, 3'h2, 32'h000003B0}, '{16'h0004, 3'h6, 32'h00001100},
		'{16'h0004, 3'h7, 32'h00001000}, '{16'h0004, 3'h3, 32'h00001100}, '{16'h0004, 3'h2, 32'h00001000},
		'{16'h0000, 3'h7, 32'h00001100}, '{16'h0000, 3'h0, 32'h00101000}};
	logic clk_sys, rstn, cfg_wr, cfg_rd, cmd_serr_en, sec_parity_error, pri_rr, pri_c, sec_rr, sec_c;
	logic master_abort, ma_rd, ma_pend, req_valid, req_dn, req_io, serr_assert, pci_clk, serr_pin_n;
	logic fwd_valid, fwd_accept, ma_rv, ma_wd, ma_ta, pri_discard, sec_discard, fast_b2b, rst_out_n;
	logic up_o, up_oe_n, dn_o, dn_oe_n, up_level, dn_level;
	logic [7:0]  cfg_addr;
	logic [1:0]  cfg_be;
	logic [15:0] cfg_wdata, cfg_rdata;
	logic [31:0] req_addr, ma_data, io_lo, io_hi, mem_lo, mem_hi;
	int          num_errors, checks, n, i;

	bridge_secondary_control #(.LONG_CLKS(64), .SHORT_CLKS(8)) uut (.clk_sys(clk_sys), .rstn(rstn),
		.pci_clk(pci_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cmd_serr_en(cmd_serr_en),
		.downstream_system_error_in_n(serr_pin_n), .sec_parity_error(sec_parity_error),
		.pri_result_ready(pri_rr), .pri_completed(pri_c), .sec_result_ready(sec_rr), .sec_completed(sec_c),
		.master_abort(master_abort), .master_abort_read(ma_rd), .master_abort_pending(ma_pend),
		.req_valid(req_valid), .req_from_primary(req_dn), .req_is_io(req_io), .req_addr(req_addr),
		.io_base(io_lo), .io_limit(io_hi), .mem_base(mem_lo), .mem_limit(mem_hi),
		.fwd_valid(fwd_valid), .fwd_accept(fwd_accept), .ma_read_valid(ma_rv), .ma_read_data(ma_data),
		.ma_write_discard(ma_wd), .ma_target_abort(ma_ta), .pri_discard(pri_discard),
		.sec_discard(sec_discard), .fast_b2b_enable(fast_b2b), .downstream_reset_out_n(rst_out_n),
		.upstream_system_error_o(up_o), .upstream_system_error_oe_n(up_oe_n),
		.downstream_parity_error_o(dn_o), .downstream_parity_error_oe_n(dn_oe_n));
	bridge_far_end far (.serr_assert(serr_assert), .up_o(up_o), .up_oe_n(up_oe_n), .dn_o(dn_o),
		.dn_oe_n(dn_oe_n), .pci_clk(pci_clk), .serr_pin_n(serr_pin_n), .up_level(up_level), .dn_level(dn_level));

	// =====================================================================
	// helpers
	// =====================================================================
	task automatic tick(); @(posedge clk_sys); #1; endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
		cfg_addr = a; cfg_be = be; cfg_wdata = d; cfg_wr = 1'b1; tick(); cfg_wr = 1'b0; tick();
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		cfg_addr = a; cfg_rd = 1'b1; tick(); cfg_rd = 1'b0; chk(cfg_rdata, exp); tick();
	endtask
	// one decode request, answer looked at while it stands
	task automatic dec(input logic dn, input logic io, input logic [31:0] a, input logic acc);
		req_dn = dn; req_io = io; req_addr = a; req_valid = 1'b1; tick(); req_valid = 1'b0;
		chk({fwd_valid, fwd_accept}, {1'b1, acc}); tick();
	endtask
	// bounded wait for a level, counting cycles
	task automatic wait_for(ref logic s, input logic v, input int lim, output int k);
		k = 0;
		while (s !== v && k < lim)
		begin
			tick(); k++;
		end
	endtask
	task automatic abort(input logic r, input logic p);
		tick(); ma_rd = r; ma_pend = p; master_abort = 1'b1; tick(); master_abort = 1'b0;
	endtask
	// arm one timer, optionally complete the request, measure the expiry
	task automatic tm(input logic pri, input logic [15:0] c, input int lo, input int hi, input logic done);
		wr(8'h3E, 2'h3, c);
		pri_rr = pri; sec_rr = !pri; tick(); pri_rr = 1'b0; sec_rr = 1'b0;
		if (done)
		begin
			repeat (20) tick();
			pri_c = pri; sec_c = !pri; tick(); pri_c = 1'b0; sec_c = 1'b0;
		end
		if (pri) wait_for(pri_discard, 1'b1, hi, n);
		else wait_for(sec_discard, 1'b1, hi, n);
		chk(n >= lo && n < hi, !done);
	endtask
	task automatic conclude();
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// =====================================================================
	// clock, watchdog, sequence
	// =====================================================================
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial
	begin
		#40000;
		num_errors++;
		conclude();
	end
	initial
	begin
		{rstn, cfg_wr, cfg_rd, cmd_serr_en, sec_parity_error, pri_rr, pri_c, sec_rr, sec_c} = '0;
		{master_abort, ma_rd, ma_pend, req_valid, req_dn, req_io, serr_assert} = '0;
		cfg_addr = 8'h00; cfg_be = 2'h0; cfg_wdata = 16'h0000; req_addr = 32'h00000000;
		{io_lo, io_hi, mem_lo, mem_hi} = {32'h00001000, 32'h00001FFF, 32'h00100000, 32'h001FFFFF};
		repeat (5) @(posedge clk_sys);
		#1 rstn = 1'b1;
		tick();
		rd(8'h3E, 16'h0000);
		chk(rst_out_n, 1'b1);
		wr(8'h3E, 2'h3, 16'hFFFF);
		chk(rst_out_n, 1'b0);
		rd(8'h3E, 16'h0B6F);
		wr(8'h3C, 2'h3, 16'h0000);
		rd(8'h3C, 16'h0000);
		wr(8'h3E, 2'h3, 16'h0000);
		chk(rst_out_n, 1'b1);
		for (i = 0; i < 17; i++)
		begin
			wr(8'h3E, 2'h3, rows[i].c);
			dec(rows[i].f[2], rows[i].f[1], rows[i].a, rows[i].f[0]);
		end
		// moved windows steer the decode
		{io_lo, io_hi, mem_lo, mem_hi} = {32'h00002000, 32'h00002FFF, 32'h00400000, 32'h004FFFFF};
		dec(1'b1, 1'b1, 32'h00002100, 1'b1);
		dec(1'b1, 1'b1, 32'h00001100, 1'b0);
		dec(1'b1, 1'b0, 32'h00400000, 1'b1);
		dec(1'b0, 1'b0, 32'h00101000, 1'b1);
		// master abort handling in both modes
		cmd_serr_en = 1'b1;
		abort(1'b1, 1'b1); chk({ma_rv, ma_wd, ma_ta}, 3'h4); chk(ma_data, 32'hFFFFFFFF);
		abort(1'b0, 1'b1); chk({ma_rv, ma_wd, ma_ta}, 3'h2);
		wr(8'h3E, 2'h3, 16'h0020);
		abort(1'b1, 1'b1); chk({ma_rv, ma_wd, ma_ta}, 3'h1);
		abort(1'b0, 1'b0); wait_for(up_oe_n, 1'b0, 3, n); chk(up_level, 1'b0);
		wait_for(up_oe_n, 1'b1, 40, n);
		cmd_serr_en = 1'b0;
		abort(1'b0, 1'b0); repeat (20) tick(); chk(up_level, 1'b1);
		// secondary system error forwarding
		wr(8'h3E, 2'h3, 16'h0002); serr_assert = 1'b1;
		repeat (20) tick(); chk(up_level, 1'b1);
		cmd_serr_en = 1'b1; wait_for(up_oe_n, 1'b0, 8, n); chk(up_level, 1'b0);
		serr_assert = 1'b0; wait_for(up_oe_n, 1'b1, 40, n);
		wr(8'h3E, 2'h3, 16'h0000); serr_assert = 1'b1;
		repeat (20) tick(); chk(up_level, 1'b1);
		serr_assert = 1'b0;
		// secondary parity reporting
		wr(8'h3E, 2'h3, 16'h0001);
		sec_parity_error = 1'b1; tick(); sec_parity_error = 1'b0; tick(); chk(dn_level, 1'b0);
		wait_for(dn_oe_n, 1'b1, 40, n);
		wr(8'h3E, 2'h3, 16'h0000);
		sec_parity_error = 1'b1; tick(); sec_parity_error = 1'b0; repeat (4) tick(); chk(dn_level, 1'b1);
		// discard timers: short primary with error signalling, sticky status
		tm(1'b1, 16'h0900, 7 * 16, 8 * 16 + 10, 1'b0);
		chk(up_oe_n, 1'b0);
		rd(8'h3E, 16'h0D00);
		wr(8'h3E, 2'h2, 16'h0D00);
		rd(8'h3E, 16'h0900);
		tm(1'b0, 16'h0800, 63 * 16, 64 * 16 + 10, 1'b0);
		chk(up_oe_n, 1'b1);
		rd(8'h3E, 16'h0C00);
		tm(1'b0, 16'h0200, 7 * 16, 8 * 16 + 10, 1'b0);
		tm(1'b1, 16'h0000, 63 * 16, 64 * 16 + 10, 1'b0);
		chk(up_oe_n, 1'b1);
		tm(1'b1, 16'h0100, 7 * 16, 8 * 16 + 10, 1'b1);
		// reset in mid-run holds the secondary bus in reset
		rstn = 1'b0; tick(); chk(rst_out_n, 1'b0);
		rstn = 1'b1; tick(); rd(8'h3E, 16'h0000);
		conclude();
	end
endmodule
`default_nettype wire
